// >>> src/bvs_pkg.sv
// Shared constants and types for the boot and voltage-ID start-up sequencer.
// Assumes a 200 MHz core clock; references are kept in quarter-millivolt units.
package bvs_pkg;

   // Core clock and timing.
   localparam int CLK_MHZ        = 200;
   localparam int CLK_NS         = 5;
   localparam int RAMP_MV_PER_US = 10;
   localparam int REF_LSB_PER_MV = 4;
   localparam int RAMP_CYC       = CLK_MHZ / (RAMP_MV_PER_US * REF_LSB_PER_MV);
   localparam int STRAP_US       = 64;
   localparam int STRAP_CYC      = STRAP_US * CLK_MHZ;
   localparam int NOTICE_NS      = 200;
   localparam int NOTICE_CYC     = NOTICE_NS / CLK_NS;

   // Reference scale: code 0 is the top voltage, each code step is 6.25 mV.
   localparam int              REF_W      = 13;
   localparam logic [REF_W-1:0] VID_TOP_Q  = 13'h1838;
   localparam logic [REF_W-1:0] VID_STEP_Q = 13'h0019;

   // Boot voltage targets, indexed by {clock pin, data pin}: 1.1, 1.0, 0.9, 0.8 V.
   localparam logic [REF_W-1:0] BOOT_Q [4] = '{13'h1130, 13'h0fa0, 13'h0e10, 13'h0c80};

   // Command frame layout, most significant bit sent first.
   localparam int FRAME_BITS  = 13;
   localparam int CMD_CORE    = 12;
   localparam int CMD_RAIL2   = 11;
   localparam int CMD_OFF     = 10;
   localparam int CMD_PS_HI   = 9;
   localparam int CMD_PS_LO   = 8;
   localparam int CMD_VID_HI  = 7;
   localparam logic [1:0] PS_L_RESET = 2'h3;

   // Strap readings in 10 ohm units; the last entry is the open-pin level.
   localparam int STRAP_W   = 16;
   localparam int BANDS     = 16;
   localparam logic [STRAP_W-1:0] BAND_NOM [BANDS] = '{
      16'h0232, 16'h0313, 16'h047e, 16'h069a, 16'h07a8, 16'h09ba, 16'h0d48, 16'h1018,
      16'h146e, 16'h1c98, 16'h253a, 16'h2f44, 16'h3c28, 16'h4718, 16'h5208, 16'h61a8};
   localparam logic [3:0] SLOW_FREQ_MIN_BAND = 4'h8;

   // Offsets in signed 10 microvolt units per band.
   localparam logic [15:0] CORE_OFS [BANDS] = '{
      16'heee9, 16'hf15a, 16'hf3cb, 16'hf63c, 16'hf8ad, 16'hfb1e, 16'hfd8f, 16'h0271,
      16'h0753, 16'h0c35, 16'h1118, 16'h1388, 16'h0ea6, 16'h09c4, 16'h04e2, 16'h0000};
   localparam logic [15:0] RAIL2_OFS [BANDS] = '{
      16'h0753, 16'h0c35, 16'h1118, 16'h1388, 16'h0ea6, 16'h09c4, 16'h04e2, 16'h0000,
      16'h0753, 16'h0c35, 16'h1118, 16'h1388, 16'h0ea6, 16'h09c4, 16'h04e2, 16'h0000};

   typedef enum logic [2:0] {
      ST_OFF,
      ST_STRAP,
      ST_RAMP,
      ST_READY,
      ST_ACTIVE,
      ST_LATCHED
   } bvs_state_t;

endpackage

// >>> src/bvs_strap_decode.sv
// Strap decoder: maps one resistance reading to a band, its offset and frequency choice.
// Assumes the reading comes from a converter on the core clock, so no synchroniser.
`timescale 1ns/1ps
`default_nettype none
module bvs_strap_decode
   import bvs_pkg::*;
#(
   parameter logic [15:0] OFFSETS [BANDS] = CORE_OFS
) (
   // Clock and reset
   input  wire logic               clk_i,
   input  wire logic               nrst_i,
   // Reading
   input  wire logic               sample_i,
   input  wire logic [STRAP_W-1:0] reading_i,
   // Decoded configuration
   output logic      [3:0]         band_o,
   output logic      [15:0]        offset_o,
   output logic                    fast_o
);

   logic [3:0]   band_next;
   logic [STRAP_W:0] mid;

   // Every reading lands in the band whose nominal value is nearest.
   always_comb begin
      band_next = 4'h0;
      mid       = '0;
      for (int i = 0; i < BANDS - 1; i++) begin
         mid = ({1'b0, BAND_NOM[i]} + {1'b0, BAND_NOM[i+1]}) >> 1;
         if ({1'b0, reading_i} > mid) begin
            band_next = 4'(i + 1);
         end
      end
   end

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         band_o   <= 4'hf;
         offset_o <= 16'h0000;
         fast_o   <= 1'b0;
      end else if (sample_i) begin
         band_o   <= band_next;
         offset_o <= OFFSETS[band_next];
         fast_o   <= (band_next < SLOW_FREQ_MIN_BAND);
      end
   end

endmodule // bvs_strap_decode
`default_nettype wire

// >>> src/bvs_link_rx.sv
// Serial command receiver on the voltage-ID bus clock.
// Assumes fixed frames of FRAME_BITS bits, sampled on the rising bus clock edge.
`timescale 1ns/1ps
`default_nettype none
module bvs_link_rx
   import bvs_pkg::*;
(
   // Link clock and reset
   input  wire logic                  link_clk_i,
   input  wire logic                  nrst_i,
   // Serial data
   input  wire logic                  data_i,
   // Received frame, toggled event
   output logic      [FRAME_BITS-1:0] frame_o,
   output logic                       frame_tgl_o
);

   logic [FRAME_BITS-1:0] shift_reg;
   logic [3:0]            bit_cnt_reg;

   // The count wraps on the last bit, so nothing waits for an edge after a frame.
   always_ff @(posedge link_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         shift_reg   <= '0;
         bit_cnt_reg <= 4'h0;
      end else begin
         shift_reg   <= {shift_reg[FRAME_BITS-2:0], data_i};
         bit_cnt_reg <= (bit_cnt_reg == 4'(FRAME_BITS - 1)) ? 4'h0 : bit_cnt_reg + 4'h1;
      end
   end

   // The frame word stays put until the next frame ends, well after the toggle is seen.
   always_ff @(posedge link_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         frame_o     <= '0;
         frame_tgl_o <= 1'b0;
      end else if (bit_cnt_reg == 4'(FRAME_BITS - 1)) begin
         frame_o     <= {shift_reg[FRAME_BITS-2:0], data_i};
         frame_tgl_o <= ~frame_tgl_o;
      end
   end

endmodule // bvs_link_rx
`default_nettype wire

// >>> src/bvs_sequencer.sv
// Start-up sequencer for a two-rail regulator controller: straps, boot code, ramp, commands.
// Assumes analog strap readings on the core clock and pins arriving asynchronously.
// What this block does
// - Sample both strap readings early in soft-start and keep them as configuration.
// - Decode core strap into one of sixteen offsets, open pin meaning zero.
// - Decode second-rail strap into its offset from the same sixteen bands.
// - Pick shared switching frequency, 300 kHz upper bands, 400 kHz lower bands.
// - Before power-ok, decode clock and data pins as a boot voltage.
// - On enable rising, capture the boot code into a hold register.
// - Ramp both references to the boot target at 10 mV per microsecond.
// - When the ramp completes, raise both power-good outputs.
// - On enable loss, stop driving both rails and drop both power-goods.
// - Treat bias loss like enable loss; restart resamples and soft-starts again.
// - With power-ok high, receive serial commands and convert codes to references.
// - A voltage command steps only the addressed rail or rails.
// - Commands steer power-saving mode, voltage changes and rail shutdown.
// - A command powering off a rail leaves power-good asserted.
// - Power-ok low steps both rails to boot code and ignores commands.
// - Power-ok high again resumes command service without soft-start.
// - Enable low clears the held boot code; restart samples it afresh.
// - Bias reset shuts both rails, drops power-goods, discards boot code.
// - A fault latches both rails off until enable cycles, boot code lost.
// - Upward steps run at 10 mV per microsecond, then send a completion notice.
`timescale 1ns/1ps
`default_nettype none
module bvs_sequencer
   import bvs_pkg::*;
#(
   parameter int unsigned STRAP_SAMPLE_CYC = STRAP_CYC,
   parameter int unsigned NOTICE_LEN_CYC   = NOTICE_CYC
) (
   // Clocks and reset
   input  wire logic               clk_i,
   input  wire logic               nrst_i,
   input  wire logic               vid_bus_clk_i,
   // Supervisory pins
   input  wire logic               enable_i,
   input  wire logic               bias_por_ok_i,
   input  wire logic               fault_i,
   input  wire logic               host_power_ok_i,
   // Serial data pin
   input  wire logic               vid_bus_data_i,
   output logic                    vid_bus_data_o,
   output logic                    vid_bus_data_oe_n_o,
   // Strap readings
   input  wire logic [STRAP_W-1:0] core_strap_i,
   input  wire logic [STRAP_W-1:0] rail2_offset_freq_strap_i,
   // Rail control
   output logic      [REF_W-1:0]   core_ref_o,
   output logic      [REF_W-1:0]   rail2_ref_o,
   output logic      [15:0]        core_offset_o,
   output logic      [15:0]        rail2_offset_o,
   output logic                    freq_400k_o,
   output logic                    core_drive_en_o,
   output logic                    rail2_drive_en_o,
   output logic      [1:0]         ps_mode_l_o,
   // Status
   output logic                    core_power_good_o,
   output logic                    rail2_power_good_o,
   output logic                    voltage_change_done_notice_o,
   output logic      [1:0]         boot_voltage_code_o,
   output logic                    boot_code_valid_o
);

   localparam int SYNC_N = 7;
   localparam int S_EN   = 0;
   localparam int S_POR  = 1;
   localparam int S_FLT  = 2;
   localparam int S_POK  = 3;
   localparam int S_CLK  = 4;
   localparam int S_DAT  = 5;
   localparam int S_TGL  = 6;

   bvs_state_t            state_reg;
   logic [SYNC_N-1:0]     sync1_reg;
   logic [SYNC_N-1:0]     sync2_reg;
   logic [SYNC_N-1:0]     async_in;
   logic                  tgl_seen_reg;
   logic [FRAME_BITS-1:0] frame;
   logic                  frame_tgl;
   logic                  supply_on;
   logic                  cmd_evt;
   logic                  cmd_take;
   logic [23:0]           strap_cnt_reg;
   logic                  strap_sample;
   logic [2:0]            tick_cnt_reg;
   logic                  tick;
   logic                  running;
   logic [1:0]            boot_code_reg;
   logic                  boot_valid_reg;
   logic [REF_W-1:0]      core_tgt_reg;
   logic [REF_W-1:0]      rail2_tgt_reg;
   logic [REF_W-1:0]      core_ref_reg;
   logic [REF_W-1:0]      rail2_ref_reg;
   logic [REF_W-1:0]      cmd_tgt;
   logic                  core_on_reg;
   logic                  rail2_on_reg;
   logic [1:0]            ps_l_reg;
   logic                  notice_pend_reg;
   logic [7:0]            notice_cnt_reg;
   logic                  at_target;
   logic                  cmd_up;

   // Voltage code to reference; codes past the bottom of the scale give zero.
   function automatic logic [REF_W-1:0] vid_to_ref(input logic [7:0] code);
      logic [REF_W+7:0] drop;
      drop = {{REF_W{1'b0}}, code} * {8'h00, VID_STEP_Q};
      if (drop > {8'h00, VID_TOP_Q}) begin
         vid_to_ref = '0;
      end else begin
         vid_to_ref = VID_TOP_Q - drop[REF_W-1:0];
      end
   endfunction

   // Every asynchronous pin input passes two flip-flops before any core-clock logic sees it.
   assign async_in = {frame_tgl, vid_bus_data_i, vid_bus_clk_i, host_power_ok_i,
                      fault_i, bias_por_ok_i, enable_i};
   for (genvar g = 0; g < SYNC_N; g++) begin : g_sync
      always_ff @(posedge clk_i or negedge nrst_i) begin
         if (!nrst_i) begin
            sync1_reg[g] <= 1'b0;
            sync2_reg[g] <= 1'b0;
         end else begin
            sync1_reg[g] <= async_in[g];
            sync2_reg[g] <= sync1_reg[g];
         end
      end
   end

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         tgl_seen_reg <= 1'b0;
      end else begin
         tgl_seen_reg <= sync2_reg[S_TGL];
      end
   end

   bvs_link_rx u_link (
      .link_clk_i  (vid_bus_clk_i),
      .nrst_i      (nrst_i),
      .data_i      (vid_bus_data_i),
      .frame_o     (frame),
      .frame_tgl_o (frame_tgl)
   );

   assign supply_on = sync2_reg[S_EN] & sync2_reg[S_POR];
   assign cmd_evt   = sync2_reg[S_TGL] ^ tgl_seen_reg;
   assign cmd_take  = cmd_evt && (state_reg == ST_ACTIVE);
   assign cmd_tgt   = vid_to_ref(frame[CMD_VID_HI:0]);
   assign running   = (state_reg == ST_RAMP) || (state_reg == ST_READY) || (state_reg == ST_ACTIVE);
   assign at_target = (core_ref_reg == core_tgt_reg) && (rail2_ref_reg == rail2_tgt_reg);
   assign cmd_up    = (frame[CMD_CORE] && (cmd_tgt > core_ref_reg)) ||
                      (frame[CMD_RAIL2] && (cmd_tgt > rail2_ref_reg));

   // Main sequence; supply loss beats a fault, and a fault beats normal progress in every state but ST_OFF.
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         state_reg <= ST_OFF;
      end else if (!supply_on) begin
         state_reg <= ST_OFF;
      end else if (sync2_reg[S_FLT] && (state_reg != ST_OFF)) begin
         state_reg <= ST_LATCHED;
      end else begin
         unique case (state_reg)
            ST_OFF:     state_reg <= ST_STRAP;
            ST_STRAP:   if (strap_sample) begin
               state_reg <= ST_RAMP;
            end
            ST_RAMP:    if (at_target) begin
               state_reg <= ST_READY;
            end
            ST_READY:   if (sync2_reg[S_POK]) begin
               state_reg <= ST_ACTIVE;
            end
            ST_ACTIVE:  if (!sync2_reg[S_POK]) begin
               state_reg <= ST_READY;
            end
            ST_LATCHED: state_reg <= ST_LATCHED;
         endcase
      end
   end

   // Strap window at the head of soft-start.
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         strap_cnt_reg <= 24'h000000;
      end else if (state_reg != ST_STRAP) begin
         strap_cnt_reg <= 24'h000000;
      end else begin
         strap_cnt_reg <= strap_cnt_reg + 24'h000001;
      end
   end
   assign strap_sample = (state_reg == ST_STRAP) && (strap_cnt_reg == 24'(STRAP_SAMPLE_CYC - 1));

   bvs_strap_decode #(.OFFSETS(CORE_OFS)) u_core_strap (
      .clk_i     (clk_i),
      .nrst_i    (nrst_i),
      .sample_i  (strap_sample),
      .reading_i (core_strap_i),
      .band_o    (),
      .offset_o  (core_offset_o),
      .fast_o    ()
   );

   bvs_strap_decode #(.OFFSETS(RAIL2_OFS)) u_rail2_strap (
      .clk_i     (clk_i),
      .nrst_i    (nrst_i),
      .sample_i  (strap_sample),
      .reading_i (rail2_offset_freq_strap_i),
      .band_o    (),
      .offset_o  (rail2_offset_o),
      .fast_o    (freq_400k_o)
   );

   // Boot code hold: captured as supply comes up, lost on supply loss or fault.
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         boot_code_reg  <= 2'h0;
         boot_valid_reg <= 1'b0;
      end else if (!supply_on || (state_reg == ST_LATCHED)) begin
         boot_code_reg  <= 2'h0;
         boot_valid_reg <= 1'b0;
      end else if (state_reg == ST_OFF) begin
         boot_code_reg  <= {sync2_reg[S_CLK], sync2_reg[S_DAT]};
         boot_valid_reg <= 1'b1;
      end
   end

   // Targets follow the boot code outside command service, else the addressed rails.
   // They load during the strap window, so the ramp never starts on a zero target and ends at once.
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         core_tgt_reg  <= '0;
         rail2_tgt_reg <= '0;
      end else if (!running && (state_reg != ST_STRAP)) begin
         core_tgt_reg  <= '0;
         rail2_tgt_reg <= '0;
      end else if (state_reg != ST_ACTIVE) begin
         core_tgt_reg  <= BOOT_Q[boot_code_reg];
         rail2_tgt_reg <= BOOT_Q[boot_code_reg];
      end else if (cmd_take && !frame[CMD_OFF]) begin
         if (frame[CMD_CORE]) begin
            core_tgt_reg <= cmd_tgt;
         end
         if (frame[CMD_RAIL2]) begin
            rail2_tgt_reg <= cmd_tgt;
         end
      end
   end

   // Step timer: one quarter millivolt every RAMP_CYC cycles.
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         tick_cnt_reg <= 3'h0;
      end else if (!running || tick) begin
         tick_cnt_reg <= 3'h0;
      end else begin
         tick_cnt_reg <= tick_cnt_reg + 3'h1;
      end
   end
   assign tick = running && (tick_cnt_reg == 3'(RAMP_CYC - 1));

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         core_ref_reg  <= '0;
         rail2_ref_reg <= '0;
      end else if (!running) begin
         core_ref_reg  <= '0;
         rail2_ref_reg <= '0;
      end else if (tick) begin
         if (core_ref_reg < core_tgt_reg) begin
            core_ref_reg <= core_ref_reg + 13'h0001;
         end else if (core_ref_reg > core_tgt_reg) begin
            core_ref_reg <= core_ref_reg - 13'h0001;
         end
         if (rail2_ref_reg < rail2_tgt_reg) begin
            rail2_ref_reg <= rail2_ref_reg + 13'h0001;
         end else if (rail2_ref_reg > rail2_tgt_reg) begin
            rail2_ref_reg <= rail2_ref_reg - 13'h0001;
         end
      end
   end

   // Rail enables and power-state bits set by commands.
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         core_on_reg  <= 1'b0;
         rail2_on_reg <= 1'b0;
         ps_l_reg     <= PS_L_RESET;
      end else if (!running) begin
         core_on_reg  <= (state_reg == ST_STRAP);
         rail2_on_reg <= (state_reg == ST_STRAP);
         ps_l_reg     <= PS_L_RESET;
      end else if (cmd_take) begin
         if (frame[CMD_CORE]) begin
            core_on_reg <= !frame[CMD_OFF];
         end
         if (frame[CMD_RAIL2]) begin
            rail2_on_reg <= !frame[CMD_OFF];
         end
         ps_l_reg <= frame[CMD_PS_HI:CMD_PS_LO];
      end
   end

   // Completion notice: upward moves wait for the reference, downward ones go at once.
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         notice_pend_reg <= 1'b0;
         notice_cnt_reg  <= 8'h00;
      end else if (state_reg != ST_ACTIVE) begin
         notice_pend_reg <= 1'b0;
         notice_cnt_reg  <= 8'h00;
      end else begin
         if (cmd_take && !frame[CMD_OFF] && cmd_up) begin
            notice_pend_reg <= 1'b1;
         end else if (notice_pend_reg && at_target) begin
            notice_pend_reg <= 1'b0;
         end
         if ((notice_pend_reg && at_target && !cmd_take) ||
             (cmd_take && !frame[CMD_OFF] && !cmd_up)) begin
            notice_cnt_reg <= 8'(NOTICE_LEN_CYC);
         end else if (notice_cnt_reg != 8'h00) begin
            notice_cnt_reg <= notice_cnt_reg - 8'h01;
         end
      end
   end

   assign voltage_change_done_notice_o = (notice_cnt_reg != 8'h00);
   assign vid_bus_data_o               = 1'b0;
   assign vid_bus_data_oe_n_o          = !voltage_change_done_notice_o;
   assign core_ref_o                   = core_ref_reg;
   assign rail2_ref_o                  = rail2_ref_reg;
   assign ps_mode_l_o                  = ps_l_reg;
   assign core_drive_en_o              = running && core_on_reg;
   assign rail2_drive_en_o             = running && rail2_on_reg;
   // Power-good ignores the per-rail enables, so a rail shut by command keeps it high.
   assign core_power_good_o            = (state_reg == ST_READY) || (state_reg == ST_ACTIVE);
   assign rail2_power_good_o           = core_power_good_o;
   assign boot_voltage_code_o          = boot_code_reg;
   assign boot_code_valid_o            = boot_valid_reg;

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!nrst_i);

   sequence s_supply_lost;
      !supply_on;
   endsequence

   sequence s_all_down;
      !core_power_good_o && !rail2_power_good_o && !core_drive_en_o && !rail2_drive_en_o;
   endsequence

   boot_capture_a: assert property ((state_reg == ST_OFF) && supply_on
      |=> boot_valid_reg && (boot_code_reg == $past(sync2_reg[S_DAT+:1] | {sync2_reg[S_CLK], 1'b0})))
      else $error("boot code not captured as supply came up");
   hold_clear_a: assert property (s_supply_lost |=> !boot_valid_reg)
      else $error("boot code kept after supply loss");
   supply_loss_a: assert property (s_supply_lost |=> s_all_down)
      else $error("rails or power-good still up after supply loss");
   ramp_rate_a: assert property (running && $changed(core_ref_reg)
      |=> (!running || $stable(core_ref_reg)) [*4])
      else $error("reference stepped faster than the ramp rate");
   ramp_done_a: assert property ((state_reg == ST_RAMP) && at_target && supply_on && !sync2_reg[S_FLT]
      |=> core_power_good_o && rail2_power_good_o)
      else $error("power-good not raised at end of ramp");
   fault_latch_a: assert property ((state_reg == ST_LATCHED) && supply_on
      |=> (state_reg == ST_LATCHED) && !core_drive_en_o && !boot_valid_reg)
      else $error("fault latch released without enable cycle");
   ignore_cmd_a: assert property (cmd_evt && (state_reg != ST_ACTIVE) && running
      |=> $stable(ps_l_reg))
      else $error("command acted on while power-ok low");
   off_keeps_good_a: assert property (cmd_take && frame[CMD_OFF] && supply_on && !sync2_reg[S_FLT]
      && sync2_reg[S_POK] |=> core_power_good_o && rail2_power_good_o)
      else $error("power-good dropped by rail power-off command");
   unaddressed_a: assert property (cmd_take && !frame[CMD_CORE] && (state_reg == ST_ACTIVE)
      && $past(state_reg) == ST_ACTIVE |=> $stable(core_tgt_reg) || (state_reg != ST_ACTIVE))
      else $error("unaddressed core target changed");

endmodule // bvs_sequencer
`default_nettype wire

// >>> verif/bvs_host_model.sv
// Host-side model of the voltage-ID bus master: boot levels, power-ok and command frames.
// Assumes frames of 13 bits; the link clock stands still between frames.
`timescale 1ns/1ps
`default_nettype none
module bvs_host_model (
   // Bus pins
   output logic vid_bus_clk_o,
   output logic vid_bus_data_o,
   output logic host_power_ok_o
);
   initial begin
      vid_bus_clk_o   = 1'b0;
      vid_bus_data_o  = 1'b0;
      host_power_ok_o = 1'b0;
   end
   task automatic set_boot(input logic [1:0] c);
      vid_bus_clk_o  <= c[1];
      vid_bus_data_o <= c[0];
   endtask
   task automatic power_ok(input logic v);
      host_power_ok_o <= v;
   endtask
   // Released data line shows the inverse of the last bit, never a stale value.
   task automatic send(input logic [12:0] f);
      for (int i = 12; i >= 0; i--) begin
         vid_bus_data_o = f[i];
         #32 vid_bus_clk_o = 1'b1;
         #32 vid_bus_clk_o = 1'b0;
      end
      vid_bus_data_o = ~f[0];
   endtask
endmodule // bvs_host_model
`default_nettype wire

// >>> verif/testbench.sv
// Self-checking bench for the start-up sequencer.
// Assumes the host model drives the bus pins and power-ok.
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import bvs_pkg::*;
   logic clk_i = 0, nrst_i = 0, enable_i = 0, bias_por_ok_i = 1, fault_i = 0;
   logic [STRAP_W-1:0] cs, rs;
   wire logic vclk, vdat, vdo, pok, oe_n, drv_c, drv_r, pg_c, pg_r, ntc, frq, bval;
   wire logic [REF_W-1:0] ref_c, ref_r;
   wire logic [15:0] ofs_c, ofs_r;
   wire logic [1:0] ps, bcode;
   int err_count = 0, total_checks = 0;
   bvs_host_model i_bvs_host_model (.vid_bus_clk_o(vclk), .vid_bus_data_o(vdat), .host_power_ok_o(pok));
   bvs_sequencer #(.STRAP_SAMPLE_CYC(20), .NOTICE_LEN_CYC(4)) i_bvs_sequencer (
      .clk_i(clk_i), .nrst_i(nrst_i), .vid_bus_clk_i(vclk), .enable_i(enable_i),
      .bias_por_ok_i(bias_por_ok_i), .fault_i(fault_i), .host_power_ok_i(pok), .vid_bus_data_i(vdat),
      .vid_bus_data_o(vdo), .vid_bus_data_oe_n_o(oe_n), .core_strap_i(cs), .rail2_offset_freq_strap_i(rs),
      .core_ref_o(ref_c), .rail2_ref_o(ref_r), .core_offset_o(ofs_c), .rail2_offset_o(ofs_r),
      .freq_400k_o(frq), .core_drive_en_o(drv_c), .rail2_drive_en_o(drv_r), .ps_mode_l_o(ps),
      .core_power_good_o(pg_c), .rail2_power_good_o(pg_r), .voltage_change_done_notice_o(ntc),
      .boot_voltage_code_o(bcode), .boot_code_valid_o(bval));
   initial forever #2.5 clk_i = ~clk_i;
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         err_count++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Waits a bounded time for power-good (sel 0) or a driven-low notice (sel 1), expecting e.
   task automatic wait_hi(input int sel, input int n, input logic e);
      logic hit;
      hit = 1'b0;
      for (int i = 0; i < n && !hit; i++) begin
         @(posedge clk_i);
         hit = ((sel == 0) ? pg_c : (ntc & ~oe_n & ~vdo)) === 1'b1;
      end
      chk({15'h0, hit}, {15'h0, e});
   endtask
   task automatic step(input logic [12:0] f, input int n, input logic e);
      fork
         i_bvs_host_model.send(f);
         wait_hi(1, n, e);
      join
      repeat (10) @(posedge clk_i);
   endtask
   task automatic close_out;
      $display("checks %0d errors %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      #400000;
      err_count++;
      close_out;
   end
   initial begin
      cs <= 16'h0232;
      rs <= 16'h1018;
      repeat (5) @(posedge clk_i);
      nrst_i <= 1'b1;
      for (int c = 3; c >= 0; c--) begin
         i_bvs_host_model.set_boot(c[1:0]);
         @(posedge clk_i) enable_i <= 1'b1;
         repeat (8) @(posedge clk_i);
         chk({14'h0, bcode}, c[15:0]);
         chk({15'h0, bval}, 16'h1);
         @(posedge clk_i) enable_i <= 1'b0;
         repeat (6) @(posedge clk_i);
         chk({15'h0, bval}, 16'h0);
      end
      $display("boot code test done");
      // A fresh reset realigns the frame counter after the clock pin sat high.
      @(posedge clk_i) nrst_i <= 1'b0;
      i_bvs_host_model.set_boot(2'h1);
      repeat (5) @(posedge clk_i);
      nrst_i <= 1'b1;
      enable_i <= 1'b1;
      repeat (60) @(posedge clk_i);
      chk(ofs_c, 16'heee9);
      chk(ofs_r, 16'h0000);
      chk({15'h0, frq}, 16'h1);
      chk({15'h0, pg_c}, 16'h0);
      wait_hi(0, 21000, 1'b1);
      chk({3'h0, ref_c}, 16'h0fa0);
      chk({3'h0, ref_r}, 16'h0fa0);
      chk({15'h0, pg_r}, 16'h1);
      $display("soft-start test done");
      i_bvs_host_model.power_ok(1'b1);
      step(13'h1168, 200, 1'b1);
      chk({14'h0, ps}, 16'h1);
      repeat (2100) @(posedge clk_i);
      chk({3'h0, ref_c}, 16'h0e10);
      chk({3'h0, ref_r}, 16'h0fa0);
      step(13'h0b48, 3000, 1'b1);
      chk({3'h0, ref_r}, 16'h1130);
      step(13'h1768, 200, 1'b0);
      chk({14'h0, drv_c, drv_r}, 16'h1);
      chk({14'h0, pg_c, pg_r}, 16'h3);
      $display("command test done");
      i_bvs_host_model.power_ok(1'b0);
      repeat (2200) @(posedge clk_i);
      chk({3'h0, ref_r}, 16'h0fa0);
      i_bvs_host_model.send(13'h0800);
      repeat (2100) @(posedge clk_i);
      chk({14'h0, ps}, 16'h3);
      chk({3'h0, ref_r}, 16'h0fa0);
      i_bvs_host_model.power_ok(1'b1);
      repeat (20) @(posedge clk_i);
      chk({14'h0, pg_c, pg_r}, 16'h3);
      @(posedge clk_i) fault_i <= 1'b1;
      repeat (6) @(posedge clk_i);
      fault_i <= 1'b0;
      repeat (10) @(posedge clk_i);
      chk({12'h0, pg_c, pg_r, drv_r, bval}, 16'h0);
      @(posedge clk_i) bias_por_ok_i <= 1'b0;
      cs <= 16'h7000;
      rs <= 16'h146e;
      repeat (6) @(posedge clk_i);
      bias_por_ok_i <= 1'b1;
      repeat (60) @(posedge clk_i);
      chk({14'h0, bval, pg_c}, 16'h2);
      chk(ofs_c, 16'h0000);
      chk(ofs_r, 16'h0753);
      chk({15'h0, frq}, 16'h0);
      enable_i <= 1'b0;
      repeat (6) @(posedge clk_i);
      chk({12'h0, pg_c, pg_r, drv_c, drv_r}, 16'h0);
      $display("supply test done");
      close_out;
   end
endmodule // testbench
`default_nettype wire
